// [core/chip_control_defs.vh]
// Offsets, field positions, reset values and timing counts of the bank
`ifndef CHIP_CONTROL_DEFS_VH
`define CHIP_CONTROL_DEFS_VH
`define CHIP_CONTROL_ZERO_OFS 8'h40
`define FC_UPD_BIT 15
`define RETRY_EXP_BIT 16
`define RETRY_LIM_LO 17
`define RETRY_LIM_HI 18
`define DISC_DIS_BIT 19
`define DISC_SHORT_BIT 20
`define CRS_TMR_LO 21
`define CRS_TMR_HI 22
`define DT_ORDER_BIT 23
`define CPL_TMR_LO 24
`define CPL_TMR_HI 25
`define ISO_EN_BIT 26
`define ISO_TC_LO 27
`define ISO_TC_HI 29
`define LOOPBACK_BIT 30
`define LOCKOUT_BIT 31
`define CRS_TMR_RST 2'h1
`define CPL_TMR_RST 2'h1
`define ISO_TC_RST 3'h1
`define RETRY_LIM_256 32'h0000_0100
`define RETRY_LIM_64K 32'h0001_0000
`define RETRY_LIM_2G 32'h8000_0000
`define DISC_SHORT_CLKS 16'h0040
`define CLK_MHZ 125
`define CRS_T0_US 25
`define CRS_T1_US 500
`define CRS_T2_US 5000
`define CRS_T3_US 25000
`define CPL_T0_US 50
`define CPL_T1_US 1000
`define CPL_T2_US 10000
`define CPL_T3_US 50000
`endif

// [core/expiry_timer.v]
// Loadable down-counting timer that pulses once on expiry
`timescale 1ns/100ps
`default_nettype none
module expiry_timer #(
  parameter W = 32
) (
  input wire clk,
  input wire reset_n,
  input wire start,
  input wire stop,
  input wire [W-1:0] load,
  output reg expired
);
  reg [W-1:0] cnt_r;
  reg run_r;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        run_r <= 1'b0;
      end else if (start) begin
        cnt_r <= load;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
          run_r <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // expiry_timer
`default_nettype wire

// [core/chip_control_bank.v]
// Chip control register bits 31 to 15 and the control logic they steer
// Operation
// - Clear bit: flow-control update every two credits; set: every credit.
// - Retry-expiry flag sets when retry counter hits its limit, sticky.
// - Retry limit field: none, 256, 64K or 2G retries; resets 00.
// - Discard-timer disable bit, with bridge control bit 27, gates timer.
// - Short bit gives 64 bus clocks, else bridge control bit 24/25.
// - Config retry timer 25us, 0.5ms, 5ms, 25ms; resets 01.
// - Ordering bit zero keeps delayed transactions completing in order.
// - Completion timer 50us, 1ms, 10ms, 50ms; resets 01.
// - Upstream memory traffic tagged TC0 unless isochronous enable set.
// - Isochronous traffic class field writable, resets to 001.
// - Loopback acts only with the given strap levels; read-only forward.
// - Lockout bit blocks primary config access: CRS forward, retry reverse.
`timescale 1ns/100ps
`default_nettype none
`include "chip_control_defs.vh"
module chip_control_bank #(
  parameter TW = 23,
  parameter CRS_T0 = `CRS_T0_US * `CLK_MHZ,
  parameter CRS_T1 = `CRS_T1_US * `CLK_MHZ,
  parameter CRS_T2 = `CRS_T2_US * `CLK_MHZ,
  parameter CRS_T3 = `CRS_T3_US * `CLK_MHZ,
  parameter CPL_T0 = `CPL_T0_US * `CLK_MHZ,
  parameter CPL_T1 = `CPL_T1_US * `CLK_MHZ,
  parameter CPL_T2 = `CPL_T2_US * `CLK_MHZ,
  parameter CPL_T3 = `CPL_T3_US * `CLK_MHZ
) (
  input wire clk,
  input wire reset_n,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  input wire cfg_from_primary,
  output reg [31:0] cfg_rdata,
  output wire cfg_accept,
  output wire cfg_reject_crs,
  output wire cfg_reject_retry,
  input wire test_strap_zero,
  input wire test_strap_one,
  input wire test_strap_two,
  input wire mask_strap_input,
  input wire reverse_mode_select,
  input wire [15:0] low_half_in,
  input wire brctl_disc_dis,
  input wire brctl_disc_fwd,
  input wire brctl_disc_rev,
  input wire [15:0] disc_long_clks,
  input wire pci_clk_en,
  input wire retry_event,
  input wire retry_reset,
  input wire credit_avail,
  output wire fc_update,
  input wire disc_start,
  input wire disc_stop,
  output wire disc_expired,
  input wire crs_start,
  input wire crs_stop,
  output wire crs_expired,
  input wire cpl_start,
  input wire cpl_stop,
  output wire cpl_expired,
  output wire dt_in_order,
  output wire [2:0] upstream_tc,
  output wire loopback_active
);
  reg [1:0] s0_r, s1_r, s2_r, sm_r, sr_r;
  reg fc_upd_r, exp_r, disc_dis_r, disc_short_r, dt_order_r, iso_en_r;
  reg loop_r, lock_r;
  reg [1:0] strap_cnt_r;
  reg [1:0] retry_lim_r, crs_sel_r, cpl_sel_r;
  reg [2:0] iso_tc_r;
  reg [31:0] retry_cnt_r;
  reg credit_half_r;
  reg [15:0] disc_cnt_r;
  reg disc_run_r, disc_exp_r;
  wire st0 = s0_r[1];
  wire st1 = s1_r[1];
  wire st2 = s2_r[1];
  wire stm = sm_r[1];
  wire srev = sr_r[1];
  wire hit = cfg_addr == `CHIP_CONTROL_ZERO_OFS;
  wire blocked = lock_r && cfg_from_primary;
  wire wr_hi = cfg_wr && hit && !blocked && cfg_be[3];
  wire wr_b2 = cfg_wr && hit && !blocked && cfg_be[2];
  wire wr_b1 = cfg_wr && hit && !blocked && cfg_be[1];
  wire [31:0] lim_val;
  wire retry_hit;
  function [TW-1:0] pick;
    input [1:0] sel;
    input [31:0] a, b, c, d;
    begin
      case (sel)
        2'h0: pick = a[TW-1:0];
        2'h1: pick = b[TW-1:0];
        2'h2: pick = c[TW-1:0];
        default: pick = d[TW-1:0];
      endcase
    end
  endfunction
  // Strap synchronisers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s0_r <= 2'h0;
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      sm_r <= 2'h0;
      sr_r <= 2'h0;
    end else begin
      s0_r <= {s0_r[0], test_strap_zero};
      s1_r <= {s1_r[0], test_strap_one};
      s2_r <= {s2_r[0], test_strap_two};
      sm_r <= {sm_r[0], mask_strap_input};
      sr_r <= {sr_r[0], reverse_mode_select};
    end
  end
  assign lim_val = (retry_lim_r == 2'h1) ? `RETRY_LIM_256 :
                   (retry_lim_r == 2'h2) ? `RETRY_LIM_64K :
                   `RETRY_LIM_2G;
  assign retry_hit = retry_event && retry_lim_r != 2'h0 &&
                     retry_cnt_r + 32'h1 >= lim_val;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fc_upd_r <= 1'b0;
      exp_r <= 1'b0;
      retry_lim_r <= 2'h0;
      disc_dis_r <= 1'b0;
      disc_short_r <= 1'b0;
      crs_sel_r <= `CRS_TMR_RST;
      dt_order_r <= 1'b0;
      cpl_sel_r <= `CPL_TMR_RST;
      iso_en_r <= 1'b0;
      iso_tc_r <= `ISO_TC_RST;
      loop_r <= 1'b0;
      lock_r <= 1'b0;
      strap_cnt_r <= 2'h0;
      retry_cnt_r <= 32'h0;
      credit_half_r <= 1'b0;
    end else begin
      // Strap caught once, after the synchroniser has filled
      if (strap_cnt_r != 2'h3) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      if (strap_cnt_r == 2'h2 && st0) begin
        lock_r <= 1'b1;
      end else if (wr_hi) begin
        lock_r <= cfg_wdata[`LOCKOUT_BIT];
      end
      if (wr_hi && srev) begin
        loop_r <= cfg_wdata[`LOOPBACK_BIT];
      end else if (!srev) begin
        loop_r <= 1'b0;
      end
      if (wr_hi) begin
        iso_tc_r <= cfg_wdata[`ISO_TC_HI:`ISO_TC_LO];
        cpl_sel_r <= cfg_wdata[`CPL_TMR_HI:`CPL_TMR_LO];
      end
      if (wr_b2) begin
        dt_order_r <= cfg_wdata[`DT_ORDER_BIT];
        crs_sel_r <= cfg_wdata[`CRS_TMR_HI:`CRS_TMR_LO];
        disc_short_r <= cfg_wdata[`DISC_SHORT_BIT];
        disc_dis_r <= cfg_wdata[`DISC_DIS_BIT];
        retry_lim_r <= cfg_wdata[`RETRY_LIM_HI:`RETRY_LIM_LO];
      end
      if (wr_hi) begin
        iso_en_r <= cfg_wdata[`ISO_EN_BIT];
      end
      if (wr_b1) begin
        fc_upd_r <= cfg_wdata[`FC_UPD_BIT];
      end
      if (retry_hit) begin
        exp_r <= 1'b1;
      end else if (wr_b2 && cfg_wdata[`RETRY_EXP_BIT]) begin
        exp_r <= 1'b0;
      end
      if (retry_reset || retry_hit) begin
        retry_cnt_r <= 32'h0;
      end else if (retry_event && retry_lim_r != 2'h0) begin
        retry_cnt_r <= retry_cnt_r + 32'h1;
      end
      if (credit_avail) begin
        credit_half_r <= fc_upd_r ? 1'b0 : !credit_half_r;
      end
    end
  end
  assign fc_update = credit_avail && (fc_upd_r || credit_half_r);
  // Discard timer counts bus clocks
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      disc_cnt_r <= 16'h0;
      disc_run_r <= 1'b0;
      disc_exp_r <= 1'b0;
    end else begin
      disc_exp_r <= 1'b0;
      if (disc_stop || disc_dis_r || brctl_disc_dis) begin
        disc_run_r <= 1'b0;
      end else if (disc_start) begin
        disc_run_r <= 1'b1;
        disc_cnt_r <= disc_short_r ? `DISC_SHORT_CLKS :
                      disc_long_clks;
      end else if (disc_run_r && pci_clk_en) begin
        if (disc_cnt_r <= 16'h1) begin
          disc_run_r <= 1'b0;
          disc_exp_r <= 1'b1;
        end else begin
          disc_cnt_r <= disc_cnt_r - 16'h1;
        end
      end
    end
  end
  assign disc_expired = disc_exp_r;
  expiry_timer #(.W(TW)) u_crs (
    .clk(clk),
    .reset_n(reset_n),
    .start(crs_start),
    .stop(crs_stop),
    .load(pick(crs_sel_r, CRS_T0, CRS_T1, CRS_T2, CRS_T3)),
    .expired(crs_expired)
  );
  expiry_timer #(.W(TW)) u_cpl (
    .clk(clk),
    .reset_n(reset_n),
    .start(cpl_start),
    .stop(cpl_stop),
    .load(pick(cpl_sel_r, CPL_T0, CPL_T1, CPL_T2, CPL_T3)),
    .expired(cpl_expired)
  );
  assign dt_in_order = !dt_order_r;
  assign upstream_tc = iso_en_r ? iso_tc_r : 3'h0;
  assign loopback_active = loop_r && !st0 && st1 && st2 && stm &&
                           srev;
  assign cfg_accept = (cfg_wr || cfg_rd) && !blocked;
  assign cfg_reject_crs = (cfg_wr || cfg_rd) && blocked && !srev;
  assign cfg_reject_retry = (cfg_wr || cfg_rd) && blocked && srev;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 32'h0;
    end else if (cfg_rd) begin
      cfg_rdata <= (hit && !blocked) ?
        {lock_r, loop_r, iso_tc_r, iso_en_r, cpl_sel_r, dt_order_r,
         crs_sel_r, disc_short_r, disc_dis_r, retry_lim_r, exp_r,
         fc_upd_r, low_half_in[14:0]} : 32'h0;
    end
  end
  // disc_fwd/rev selection done outside through disc_long_clks
  wire unused_ok = brctl_disc_fwd ^ brctl_disc_rev ^ low_half_in[15];
endmodule // chip_control_bank
`default_nettype wire

// [testbench/chip_control_bank_props.sv]
// Port checker for the chip control bank
`timescale 1ns/100ps
`default_nettype none
module chip_control_bank_props (
  input wire clk,
  input wire reset_n,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  input wire cfg_from_primary,
  input wire [31:0] cfg_rdata,
  input wire cfg_accept,
  input wire cfg_reject_crs,
  input wire cfg_reject_retry,
  input wire reverse_mode_select,
  input wire dt_in_order,
  input wire [2:0] upstream_tc,
  input wire loopback_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire req = cfg_wr | cfg_rd;
  wire rej = cfg_reject_crs | cfg_reject_retry;
  wire hit = cfg_wr & cfg_accept & (cfg_addr == 8'h40);
  sec_ok_a: assert property (
    req && !cfg_from_primary |-> cfg_accept) else $error("sec refused");
  rej_cause_a: assert property (
    rej |-> req && cfg_from_primary && !cfg_accept) else $error("bad reject");
  rej_one_a: assert property (
    cfg_reject_crs |-> !cfg_reject_retry) else $error("two rejects");
  blocked_zero_a: assert property (
    cfg_rd && rej |=> cfg_rdata == 32'h0) else $error("blocked data");
  tc_map_a: assert property (
    hit && cfg_be[3] |=> upstream_tc == ($past(cfg_wdata[26]) ?
    $past(cfg_wdata[29:27]) : 3'h0)) else $error("tc wrong");
  order_map_a: assert property (
    hit && cfg_be[2] |=> dt_in_order == !$past(cfg_wdata[23]))
    else $error("order wrong");
  rst_val_a: assert property (
    $rose(reset_n) |-> dt_in_order && upstream_tc == 3'h0)
    else $error("reset outputs");
  loop_drop_a: assert property (
    $fell(reverse_mode_select) |-> ##4 !loopback_active)
    else $error("loopback kept");
  cover property (cfg_reject_crs);
  cover property (cfg_reject_retry);
  cover property (loopback_active);
endmodule // chip_control_bank_props
`default_nettype wire

// [testbench/link_peer.sv]
// Far-side source of credit or retry pulses
`timescale 1ns/100ps
`default_nettype none
module link_peer (
  input wire clk,
  input wire reset_n,
  input wire go,
  input wire [8:0] n,
  input wire slow,
  input wire fc_update,
  output logic credit_avail,
  output logic [8:0] upd
);
  logic [8:0] left;
  logic ph;
  // Slow mode leaves a gap cycle between pulses
  wire fire = !go && left != 9'h0 && (!slow || ph);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {left, ph, credit_avail, upd} <= 20'h0;
    end else begin
      ph <= ~ph;
      credit_avail <= fire;
      left <= go ? n : left - {8'h0, fire};
      upd <= go ? 9'h0 : upd + {8'h0, fc_update};
    end
  end
endmodule // link_peer
`default_nettype wire

// [testbench/tb_chip_control_bank.sv]
// Self-checking bench for the chip control bank
`timescale 1ns/100ps
`default_nettype none
module tb_chip_control_bank;
  logic clk = 0, reset_n = 0, cfg_wr = 0, cfg_rd = 0, cfg_from_primary = 0;
  logic brctl_disc_dis = 0, pci_clk_en = 0, retry_reset = 0, gc = 0, gr = 0;
  logic [3:0] sx = 4'he;
  logic reverse_mode_select = 0, slow = 0;
  logic [7:0] cfg_addr = 8'h40;
  logic [3:0] cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 0, d;
  logic [15:0] low_half_in = 16'h1234, disc_long_clks = 16'h0050;
  logic [2:0] st = 0, sp = 0, flg;
  logic [8:0] n = 0;
  wire [31:0] cfg_rdata;
  wire [8:0] upd;
  wire [2:0] upstream_tc;
  wire cfg_accept, cfg_reject_crs, cfg_reject_retry, fc_update, credit_avail;
  wire retry_event, disc_expired, crs_expired, cpl_expired, dt_in_order;
  wire loopback_active;
  wire [2:0] ex = {disc_expired, cpl_expired, crs_expired};
  int fail_count = 0, samples_checked = 0, c;
  chip_control_bank #(.CRS_T0(20), .CRS_T1(30), .CRS_T2(40), .CRS_T3(50),
    .CPL_T0(24), .CPL_T1(34), .CPL_T2(44), .CPL_T3(54)) i_dut (
    .clk, .reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_from_primary, .cfg_rdata, .cfg_accept, .cfg_reject_crs,
    .cfg_reject_retry, .test_strap_zero(sx[0]), .test_strap_one(sx[1]),
    .test_strap_two(sx[2]), .mask_strap_input(sx[3]), .reverse_mode_select,
    .low_half_in, .brctl_disc_dis,
    .brctl_disc_fwd(1'b0), .brctl_disc_rev(1'b0), .disc_long_clks,
    .pci_clk_en, .retry_event, .retry_reset, .credit_avail, .fc_update,
    .disc_start(st[2]), .disc_stop(sp[2]), .disc_expired, .crs_start(st[0]),
    .crs_stop(sp[0]), .crs_expired, .cpl_start(st[1]), .cpl_stop(sp[1]),
    .cpl_expired, .dt_in_order, .upstream_tc, .loopback_active);
  link_peer i_cred (.clk, .reset_n, .go(gc), .n, .slow, .fc_update,
    .credit_avail, .upd);
  link_peer i_retry (.clk, .reset_n, .go(gr), .n, .slow, .fc_update(1'b0),
    .credit_avail(retry_event), .upd());
  always #4 clk = ~clk;
  always @(posedge clk) pci_clk_en <= ~pci_clk_en;
  task chk(input string s, input [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task xfer(input r, p, input [7:0] a, input [3:0] b, input [31:0] w);
    @(posedge clk) {cfg_wr, cfg_rd, cfg_from_primary} <= {!r, r, p};
    {cfg_addr, cfg_be, cfg_wdata} <= {a, b, w};
    #4 flg = {cfg_accept, cfg_reject_crs, cfg_reject_retry};
    @(posedge clk) {cfg_wr, cfg_rd} <= 2'b00;
    #1 d = cfg_rdata;
  endtask
  task wr(input p, input [3:0] b, input [31:0] w); xfer(0, p, 8'h40, b, w);
  endtask
  task rd(input p); xfer(1, p, 8'h40, 4'hf, 0);
  endtask
  task tm(input int w, e, input bit s = 1'b0);
    @(posedge clk) st[w] <= 1'b1;
    @(posedge clk) {st[w], sp[w]} <= {1'b0, s};
    @(posedge clk) sp[w] <= 1'b0;
    #1 for (c = 1; c < 400 && ex[w] !== 1'b1; c++) #8;
    chk("timer", 1, c >= e - 2 && c <= e + 3);
  endtask
  task pulses(input r, input [8:0] k, input s);
    @(posedge clk) {gc, gr, n, slow} <= {!r, r, k, s};
    @(posedge clk) {gc, gr} <= 2'b00;
    repeat (2 * k + 4) @(posedge clk);
  endtask
  task complete_run;
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000 fail_count++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(0);
    chk("rst", 32'h0920_1234, d);
    wr(0, 4'hf, 32'hffff_8000);
    rd(0);
    chk("all", 32'hbffe_9234, d);
    chk("tc", 7, upstream_tc);
    chk("ord", 0, dt_in_order);
    xfer(0, 0, 8'h44, 4'hf, 32'hffff_ffff);
    rd(0);
    chk("miss", 32'hbffe_9234, d);
    xfer(1, 0, 8'h44, 4'hf, 0);
    chk("mrd", 0, d);
    rd(1);
    chk("crs", 3'b010, flg);
    chk("blk", 0, d);
    wr(1, 4'h8, 0);
    @(posedge clk) reverse_mode_select <= 1'b1;
    repeat (4) @(posedge clk);
    rd(1);
    chk("rty", 3'b001, flg);
    rd(0);
    chk("lock", 1, d[31]);
    wr(0, 4'h8, 32'h4000_0000);
    chk("loop", 1, loopback_active);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) sx <= 4'he ^ (4'h1 << k);
      repeat (4) @(posedge clk);
      chk("lpstrap", 0, loopback_active);
    end
    @(posedge clk) sx <= 4'he;
    repeat (4) @(posedge clk);
    chk("lpback", 1, loopback_active);
    rd(1);
    chk("open", 3'b100, flg);
    @(posedge clk) reverse_mode_select <= 1'b0;
    repeat (4) @(posedge clk);
    chk("lpoff", 0, loopback_active);
    wr(0, 4'h8, 32'h7800_0000);
    rd(0);
    chk("lpro", 0, d[30]);
    chk("tc0", 0, upstream_tc);
    wr(0, 4'h2, 0);
    pulses(0, 4, 1);
    chk("fc2", 2, upd);
    wr(0, 4'h2, 32'h8000);
    pulses(0, 4, 0);
    chk("fc1", 4, upd);
    @(posedge clk) retry_reset <= 1'b1;
    @(posedge clk) retry_reset <= 1'b0;
    wr(0, 4'h4, 32'h2_0000);
    pulses(1, 255, 0);
    rd(0);
    chk("rx0", 0, d[16]);
    pulses(1, 1, 0);
    rd(0);
    chk("rx1", 1, d[16]);
    wr(0, 4'h4, 32'h2_0000);
    rd(0);
    chk("rx1", 1, d[16]);
    wr(0, 4'h4, 32'h1_0000);
    rd(0);
    chk("rx0", 0, d[16]);
    for (int k = 0; k < 4; k++) begin
      wr(0, 4'hc, 32'h0120_0000 * k | 32'h0010_0000);
      tm(0, 20 + 10 * k);
      tm(1, 24 + 10 * k);
    end
    tm(2, 128);
    wr(0, 4'hc, 0);
    tm(2, 160);
    wr(0, 4'hc, 32'h0008_0000);
    tm(2, 400);
    wr(0, 4'hc, 0);
    @(posedge clk) brctl_disc_dis <= 1'b1;
    tm(2, 400);
    @(posedge clk) brctl_disc_dis <= 1'b0;
    for (int k = 0; k < 3; k++) tm(k, 400, 1'b1);
    @(posedge clk) {sx[0], reset_n} <= 2'b10;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(0);
    chk("lkrst", 1, d[31]);
    complete_run;
  end
endmodule // tb_chip_control_bank
bind chip_control_bank chip_control_bank_props i_props (.clk, .reset_n,
  .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_from_primary,
  .cfg_rdata, .cfg_accept, .cfg_reject_crs, .cfg_reject_retry,
  .reverse_mode_select, .dt_in_order, .upstream_tc, .loopback_active);
`default_nettype wire
